// ===== hdl/mes_status_map.vh
// Register offsets, field positions, reset values and timing constants of the event status block.
`ifndef MES_STATUS_MAP_VH
`define MES_STATUS_MAP_VH

`define MES_ADDR_STATUS 8'h00
`define MES_ADDR_MASK 8'h04
`define MES_ADDR_PHASE 8'h08
`define MES_ADDR_CONFIG 8'h0C
`define MES_ADDR_THRESH 8'h10

`define MES_SEL_W 5
`define MES_SEL_STATUS 0
`define MES_SEL_MASK 1
`define MES_SEL_PHASE 2
`define MES_SEL_CONFIG 3
`define MES_SEL_THRESH 4

`define MES_STICKY_BITS 32'h019FFFFF
`define MES_FIXED_ONES 32'h00200000
`define MES_STATUS_RESET 32'h00000000
`define MES_MASK_RESET 32'h00000000
`define MES_BIT_RESET_DONE 15
`define MES_BIT_MISMATCH 20
`define MES_BIT_SAG 16
`define MES_BIT_OVERCURRENT 17
`define MES_BIT_OVERVOLTAGE 18

`define MES_BIT_SOFTWARE_RESET_REQUEST 7
`define MES_CFG_MODE_MSB 1
`define MES_CFG_MODE_LSB 0
`define MES_MODE_NORMAL 2'h0
`define MES_MODE_RESET 2'h0

`define MES_PH_OI_LSB 3
`define MES_PH_OV_LSB 9
`define MES_PH_SAG_LSB 12
`define MES_PH_W 15

`define MES_RESP_OKAY 2'h0
`define MES_RESP_SLVERR 2'h2

`define MES_SETTLE_NS 1000
`define MES_CLK_MHZ 50
`define MES_CNT_W 16

`endif

// ===== hdl/mes_status_upper.v
// Event status word with sticky flags, mask, interrupt and AXI4-Lite register access.
`timescale 1ns/1ps
`include "mes_status_map.vh"

// Notes on behaviour
// - Current zero-cross events of phases A, B, C set status bits 12, 13, 14.
// - Reset-complete bit 15 sets only after the settle period restores all defaults.
// - Software reset bit 7, hardware reset, or low-power to normal start that settle.
// - Reset-complete drives the interrupt output low and no mask can block it.
// - Reset-complete reads 1 as its default once the device has come up.
// - Voltage sag on any phase sets bit 16; phases latch in phase bits 14 to 12.
// - Overcurrent on any phase sets bit 17; phases latch in phase bits 5 to 3.
// - Overvoltage on any phase sets bit 18; phases latch in phase bits 11 to 9.
// - Rising A voltage crossing followed by rising C instead of B sets bit 19.
// - Absolute current sum minus neutral above threshold sets bit 20; zero without neutral.
// - Reserved bit 21 always reads 1.
// - Reserved bit 22 always reads 0.
// - End of current peak detection period sets bit 23.
// - End of voltage peak detection period sets bit 24.
// - Reserved bits 31 to 25 always read 0.
// - Bits 11 to 0 carry the lower flags, supplied as events from outside.
module mes_status_upper #(
    parameter DATA_W = 24,
    parameter HAS_NEUTRAL = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [11:0] lower_event,
    input wire [2:0] current_zero_cross_event,
    input wire [2:0] voltage_rising_cross_event,
    input wire [2:0] sag_event,
    input wire [2:0] overcurrent_event,
    input wire [2:0] overvoltage_event,
    input wire current_peak_done_event,
    input wire voltage_peak_done_event,
    input wire signed [DATA_W-1:0] summed_phase_current,
    input wire signed [DATA_W-1:0] neutral_current_sample,
    output reg interrupt_request_one_n,
    output reg [1:0] power_mode
);

    localparam [`MES_CNT_W-1:0] SETTLE_CYCLES = (`MES_SETTLE_NS * `MES_CLK_MHZ + 999) / 1000;
    localparam [`MES_CNT_W-1:0] SETTLE_LAST = SETTLE_CYCLES - 1'b1;
    localparam [1:0] SEQ_IDLE = 2'b01;
    localparam [1:0] SEQ_WAIT_B = 2'b10;

    function [`MES_SEL_W-1:0] mes_decode;
        input [7:0] addr;
        begin
            mes_decode = {`MES_SEL_W{1'b0}};
            case (addr)
                `MES_ADDR_STATUS: mes_decode[`MES_SEL_STATUS] = 1'b1;
                `MES_ADDR_MASK: mes_decode[`MES_SEL_MASK] = 1'b1;
                `MES_ADDR_PHASE: mes_decode[`MES_SEL_PHASE] = 1'b1;
                `MES_ADDR_CONFIG: mes_decode[`MES_SEL_CONFIG] = 1'b1;
                `MES_ADDR_THRESH: mes_decode[`MES_SEL_THRESH] = 1'b1;
                default: mes_decode = {`MES_SEL_W{1'b0}};
            endcase
        end
    endfunction

    function [31:0] mes_strb_mask;
        input [3:0] strb;
        begin
            mes_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    reg aw_held;
    reg [7:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] status;
    reg [31:0] mask;
    reg [`MES_PH_W-1:0] phase_status;
    reg [DATA_W-1:0] threshold;
    reg settling;
    reg [`MES_CNT_W-1:0] settle_cnt;
    reg [1:0] seq_state;

    reg next_aw_held;
    reg [7:0] next_aw_addr;
    reg next_w_held;
    reg [31:0] next_w_data;
    reg [3:0] next_w_strb;
    reg next_awready;
    reg next_wready;
    reg next_bvalid;
    reg [1:0] next_bresp;
    reg next_arready;
    reg next_rvalid;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    reg [31:0] next_status;
    reg [31:0] next_mask;
    reg [`MES_PH_W-1:0] next_phase_status;
    reg [DATA_W-1:0] next_threshold;
    reg [1:0] next_power_mode;
    reg next_settling;
    reg [`MES_CNT_W-1:0] next_settle_cnt;
    reg [1:0] next_seq_state;
    reg next_irq_n;

    reg do_write;
    reg [`MES_SEL_W-1:0] wsel;
    reg [`MES_SEL_W-1:0] rsel;
    reg [31:0] wmask;
    reg [31:0] clr;
    reg [31:0] set_vec;
    reg [31:0] status_view;
    reg seq_error;
    reg restart;
    reg signed [DATA_W:0] diff;
    reg [DATA_W:0] abs_diff;
    reg mismatch;

    always @* begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_mask = mask;
        next_threshold = threshold;
        next_power_mode = power_mode;
        next_settling = settling;
        next_settle_cnt = settle_cnt;
        next_seq_state = seq_state;
        restart = 1'b0;
        seq_error = 1'b0;

        // Status as software sees it: reserved bits forced, lower half and upper flags live.
        status_view = (status & `MES_STICKY_BITS) | `MES_FIXED_ONES;

        // Write address and data are captured independently, then committed together.
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held && !s_axi_bvalid;
        wsel = mes_decode(aw_addr);
        wmask = mes_strb_mask(w_strb);
        clr = 32'h00000000;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wsel == {`MES_SEL_W{1'b0}}) ? `MES_RESP_SLVERR : `MES_RESP_OKAY;
            if (!settling) begin
                if (wsel[`MES_SEL_STATUS]) begin
                    clr = w_data & wmask & `MES_STICKY_BITS;
                end
                if (wsel[`MES_SEL_MASK]) begin
                    next_mask = (mask & ~wmask) | (w_data & wmask & `MES_STICKY_BITS);
                end
                if (wsel[`MES_SEL_THRESH]) begin
                    next_threshold = (threshold & ~wmask[DATA_W-1:0]) | (w_data[DATA_W-1:0] & wmask[DATA_W-1:0]);
                end
                if (wsel[`MES_SEL_CONFIG] && w_strb[0]) begin
                    next_power_mode = w_data[`MES_CFG_MODE_MSB:`MES_CFG_MODE_LSB];
                    if (w_data[`MES_BIT_SOFTWARE_RESET_REQUEST]) begin
                        restart = 1'b1;
                    end else if (power_mode != `MES_MODE_NORMAL && next_power_mode == `MES_MODE_NORMAL) begin
                        restart = 1'b1;
                    end
                end
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;

        // Reads answer one cycle after the address is taken.
        rsel = mes_decode(s_axi_araddr);
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = (rsel == {`MES_SEL_W{1'b0}}) ? `MES_RESP_SLVERR : `MES_RESP_OKAY;
            next_rdata = 32'h00000000;
            case (1'b1)
                rsel[`MES_SEL_STATUS]: next_rdata = status_view;
                rsel[`MES_SEL_MASK]: next_rdata = mask;
                rsel[`MES_SEL_PHASE]: next_rdata = {{(32-`MES_PH_W){1'b0}}, phase_status};
                rsel[`MES_SEL_CONFIG]: next_rdata = {30'h00000000, power_mode};
                rsel[`MES_SEL_THRESH]: next_rdata = {{(32-DATA_W){1'b0}}, threshold};
                default: next_rdata = 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_arready = !next_rvalid;

        // Phase order checker: after a rising A crossing, C arriving before B is an error.
        case (seq_state)
            SEQ_IDLE: begin
                if (voltage_rising_cross_event[0]) begin
                    next_seq_state = SEQ_WAIT_B;
                end
            end
            SEQ_WAIT_B: begin
                if (voltage_rising_cross_event[1]) begin
                    next_seq_state = SEQ_IDLE;
                end else if (voltage_rising_cross_event[2]) begin
                    seq_error = 1'b1;
                    next_seq_state = SEQ_IDLE;
                end
            end
            default: next_seq_state = SEQ_IDLE;
        endcase

        // Neutral mismatch compares magnitude of the difference against the threshold.
        diff = {summed_phase_current[DATA_W-1], summed_phase_current} -
               {neutral_current_sample[DATA_W-1], neutral_current_sample};
        abs_diff = diff[DATA_W] ? (~diff + 1'b1) : diff;
        mismatch = (HAS_NEUTRAL != 0) && (abs_diff > {1'b0, threshold});

        set_vec = {7'h00, voltage_peak_done_event, current_peak_done_event, 2'b00,
                   mismatch, seq_error, |overvoltage_event, |overcurrent_event, |sag_event,
                   1'b0, current_zero_cross_event, lower_event};
        // A new event in the clearing cycle wins over the clear.
        next_status = (status & ~clr) | (set_vec & `MES_STICKY_BITS);
        next_phase_status = phase_status;
        next_phase_status[`MES_PH_SAG_LSB+2:`MES_PH_SAG_LSB] =
            (phase_status[`MES_PH_SAG_LSB+2:`MES_PH_SAG_LSB] & ~{3{clr[`MES_BIT_SAG]}}) | sag_event;
        next_phase_status[`MES_PH_OI_LSB+2:`MES_PH_OI_LSB] =
            (phase_status[`MES_PH_OI_LSB+2:`MES_PH_OI_LSB] & ~{3{clr[`MES_BIT_OVERCURRENT]}}) | overcurrent_event;
        next_phase_status[`MES_PH_OV_LSB+2:`MES_PH_OV_LSB] =
            (phase_status[`MES_PH_OV_LSB+2:`MES_PH_OV_LSB] & ~{3{clr[`MES_BIT_OVERVOLTAGE]}}) | overvoltage_event;

        // While settling every register sits at its default; the end raises reset-complete.
        if (restart) begin
            next_settling = 1'b1;
            next_settle_cnt = {`MES_CNT_W{1'b0}};
        end
        if (settling || restart) begin
            next_status = `MES_STATUS_RESET;
            next_mask = `MES_MASK_RESET;
            next_phase_status = {`MES_PH_W{1'b0}};
            next_threshold = {DATA_W{1'b0}};
            next_power_mode = `MES_MODE_RESET;
            next_seq_state = SEQ_IDLE;
        end
        if (settling && !restart) begin
            if (settle_cnt == SETTLE_LAST) begin
                next_settling = 1'b0;
                next_status[`MES_BIT_RESET_DONE] = 1'b1;
            end else begin
                next_settle_cnt = settle_cnt + 1'b1;
            end
        end

        // Reset-complete bypasses the mask.
        next_irq_n = !((|(next_status & next_mask & `MES_STICKY_BITS)) || next_status[`MES_BIT_RESET_DONE]);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MES_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MES_RESP_OKAY;
            status <= `MES_STATUS_RESET;
            mask <= `MES_MASK_RESET;
            phase_status <= {`MES_PH_W{1'b0}};
            threshold <= {DATA_W{1'b0}};
            power_mode <= `MES_MODE_RESET;
            settling <= 1'b1;
            settle_cnt <= {`MES_CNT_W{1'b0}};
            seq_state <= SEQ_IDLE;
            interrupt_request_one_n <= 1'b1;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            status <= next_status;
            mask <= next_mask;
            phase_status <= next_phase_status;
            threshold <= next_threshold;
            power_mode <= next_power_mode;
            settling <= next_settling;
            settle_cnt <= next_settle_cnt;
            seq_state <= next_seq_state;
            interrupt_request_one_n <= next_irq_n;
        end
    end

endmodule // mes_status_upper

// ===== sim/mes_status_upper_properties.sv
// Port-level assertions for the event status block.
`timescale 1ns/1ps
module mes_status_upper_properties (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire interrupt_request_one_n,
    input wire [1:0] power_mode
);
    default clocking cb @(posedge aclk);
    endclocking
    chk_reset_quiet: assert property (
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && interrupt_request_one_n && power_mode == 2'h0)
        else $error("outputs not idle after reset");
    chk_settle_high: assert property (
        disable iff (!aresetn) $rose(aresetn) |-> interrupt_request_one_n [*8])
        else $error("interrupt before settle ended");
    chk_settle_low: assert property (
        disable iff (!aresetn) $rose(aresetn) |-> ##[40:60] !interrupt_request_one_n)
        else $error("no interrupt after settle");
    chk_mode_normal: assert property (
        disable iff (!aresetn) $rose(aresetn) |-> (power_mode == 2'h0) [*4])
        else $error("power mode not normal after reset");
    chk_aw_close: assert property (
        disable iff (!aresetn) (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
        else $error("address ready not dropped");
    chk_b_latency: assert property (
        disable iff (!aresetn)
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing wrong");
    chk_r_latency: assert property (
        disable iff (!aresetn) (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data timing wrong");
    chk_r_release: assert property (
        disable iff (!aresetn) (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
        else $error("read data not released");
    chk_ar_block: assert property (
        disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while busy");
endmodule // mes_status_upper_properties

bind mes_status_upper mes_status_upper_properties mes_status_upper_properties_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .interrupt_request_one_n, .power_mode);

// ===== sim/mes_host_model.sv
// Host software model that runs register cycles and notes expected reads.
`timescale 1ns/1ps
module mes_host_model (
    input logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic [33:0] exp_q[$];
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        exp_q.push_back(e);
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule // mes_host_model

// ===== sim/mes_status_upper_tb.sv
// Self-checking bench for the event status block.
`timescale 1ns/1ps
module mes_status_upper_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, interrupt_request_one_n;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_mode, resp;
    logic [25:0] ev = 26'h0;
    logic [25:0] r;
    logic [2:0] voltage_rising_cross_event = 3'h0;
    logic signed [23:0] summed_phase_current = 24'sh000000;
    logic signed [23:0] neutral_current_sample = 24'sh000000;
    wire [11:0] lower_event = ev[11:0];
    wire [2:0] current_zero_cross_event = ev[14:12];
    wire [2:0] sag_event = ev[17:15];
    wire [2:0] overcurrent_event = ev[20:18];
    wire [2:0] overvoltage_event = ev[23:21];
    wire current_peak_done_event = ev[24];
    wire voltage_peak_done_event = ev[25];
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    mes_status_upper mes_status_upper_i (.*);
    mes_host_model mes_host_model_i (.*);
    initial begin
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // Each read answer is compared with the oldest note the host left.
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            chk("read", {s_axi_rresp, s_axi_rdata}, mes_host_model_i.exp_q.pop_front());
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mes_host_model_i.wr(a, d, resp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        mes_host_model_i.rd(a, {2'h0, e});
    endtask
    task automatic pulse(input logic [25:0] v);
        @(posedge aclk);
        ev <= v;
        @(posedge aclk);
        ev <= 26'h0;
    endtask
    task automatic vp(input logic [2:0] v);
        @(posedge aclk);
        voltage_rising_cross_event <= v;
        @(posedge aclk);
        voltage_rising_cross_event <= 3'h0;
    endtask
    task automatic settle();
        repeat (60) @(posedge aclk);
    endtask
    function automatic logic [31:0] st(input logic [25:0] v);
        return {7'h00, v[25:24], 4'h4, |v[23:21], |v[20:18], |v[17:15], 1'b0, v[14:0]};
    endfunction
    function automatic logic [31:0] ph(input logic [25:0] v);
        return {17'h0, v[17:15], v[23:21], 3'h0, v[20:18], 3'h0};
    endfunction
    initial begin
        void'($urandom(32'h5410));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h00200000);
        settle();
        rd(8'h00, 32'h00208000);
        chk("irq", interrupt_request_one_n, 1'b0);
        rd(8'h04, 32'h00000000);
        wr(8'h00, 32'h00008000);
        rd(8'h00, 32'h00200000);
        chk("irq", interrupt_request_one_n, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 30; i++) begin
            r = (i < 26) ? (26'h1 << i) : 26'($urandom);
            pulse(r);
            repeat (3) @(posedge aclk);
            rd(8'h00, st(r));
            rd(8'h08, ph(r));
            wr(8'h00, 32'hFFFFFFFF);
            rd(8'h00, 32'h00200000);
            rd(8'h08, 32'h00000000);
        end
        $display("test events done");
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h019FFFFF);
        wr(8'h04, 32'h00010000);
        chk("bresp", resp, 2'h0);
        pulse(26'h0010000);
        repeat (2) @(posedge aclk);
        chk("irq", interrupt_request_one_n, 1'b0);
        rd(8'h08, 32'h00002000);
        wr(8'h04, 32'h00000000);
        wr(8'h00, 32'h00010000);
        rd(8'h08, 32'h00000000);
        $display("test mask done");
        vp(3'h1);
        vp(3'h4);
        rd(8'h00, 32'h00280000);
        wr(8'h00, 32'h00080000);
        vp(3'h1);
        vp(3'h2);
        vp(3'h4);
        rd(8'h00, 32'h00200000);
        $display("test order done");
        wr(8'h10, 32'h0000000A);
        summed_phase_current <= 24'sd100;
        neutral_current_sample <= 24'sd110;
        repeat (3) @(posedge aclk);
        rd(8'h00, 32'h00200000);
        summed_phase_current <= 24'sd121;
        repeat (3) @(posedge aclk);
        neutral_current_sample <= 24'sd121;
        rd(8'h00, 32'h00300000);
        wr(8'h00, 32'h00100000);
        rd(8'h00, 32'h00200000);
        $display("test mismatch done");
        wr(8'h0C, 32'h00000001);
        repeat (2) @(posedge aclk);
        chk("mode", power_mode, 2'h1);
        wr(8'h0C, 32'h00000000);
        rd(8'h00, 32'h00200000);
        settle();
        rd(8'h00, 32'h00208000);
        wr(8'h00, 32'h00008000);
        wr(8'h0C, 32'h00000080);
        settle();
        rd(8'h00, 32'h00208000);
        chk("irq", interrupt_request_one_n, 1'b0);
        $display("test restart done");
        mes_host_model_i.rd(8'h20, {2'h2, 32'h0});
        wr(8'h20, 32'h00000001);
        chk("bresp", resp, 2'h2);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule // mes_status_upper_tb
